// [iepb_map.svh]
// register offsets, implemented-bit masks and reset values of the enable and priority bank
`ifndef IEPB_MAP_SVH
`define IEPB_MAP_SVH

// ***********************************************
// register offsets (word index on reg_addr)
// ***********************************************
`define IEPB_OFS_EN1 4'h0
`define IEPB_OFS_EN3 4'h1
`define IEPB_OFS_EN4 4'h2
`define IEPB_OFS_PRI0 4'h3
`define IEPB_OFS_PRI1 4'h4
`define IEPB_OFS_PRI2 4'h5
`define IEPB_OFS_PRI3 4'h6
`define IEPB_OFS_PRI4 4'h7

// ***********************************************
// implemented bits
// ***********************************************
`define IEPB_MASK_EN1 16'hE01F
`define IEPB_MASK_EN3 16'h4000
`define IEPB_MASK_EN4 16'h210E
`define IEPB_MASK_PRI0 16'h7777
`define IEPB_MASK_PRI1 16'h7000
`define IEPB_MASK_PRI2 16'h7777
`define IEPB_MASK_PRI3 16'h7077
`define IEPB_MASK_PRI4 16'h7777

// ***********************************************
// power-on values
// ***********************************************
`define IEPB_RST_EN 16'h0000
`define IEPB_RST_PRI0 16'h4444
`define IEPB_RST_PRI1 16'h4000
`define IEPB_RST_PRI2 16'h4444
`define IEPB_RST_PRI3 16'h4044
`define IEPB_RST_PRI4 16'h4444
`define IEPB_PRI_FIELD_RST 3'h4
`define IEPB_PRI_OFF 3'h0
`define IEPB_PRI_TOP 3'h7
`define IEPB_PRI_BOTTOM 3'h1

// ***********************************************
// field positions
// ***********************************************
`define IEPB_F_HI 14:12
`define IEPB_F_MH 10:8
`define IEPB_F_ML 6:4
`define IEPB_F_LO 2:0
`define IEPB_B_U2TX 15
`define IEPB_B_U2RX 14
`define IEPB_B_EXT2 13
`define IEPB_B_EXT1 4
`define IEPB_B_CN 3
`define IEPB_B_CMP 2
`define IEPB_B_I2CM 1
`define IEPB_B_I2CS 0
`define IEPB_B_RTC 14
`define IEPB_B_CHG 13
`define IEPB_B_HLV 8
`define IEPB_B_CRC 3
`define IEPB_B_U2ER 2
`define IEPB_B_U1ER 1

`endif

// [iepb_pkg.sv]
// types shared by the interrupt enable and priority bank
`default_nettype none
package iepb_pkg;

  typedef logic [2:0] iepb_level_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } iepb_bus_req_t;

  typedef struct packed {
    logic uart2_transmit_irq_enable;
    logic uart2_receive_irq_enable;
    logic ext_input2_irq_enable;
    logic ext_input1_irq_enable;
    logic change_notify_irq_enable;
    logic comparator_irq_enable;
    logic i2c_master_event_irq_enable;
    logic i2c_slave_event_irq_enable;
    logic clock_calendar_irq_enable;
    logic charge_measure_irq_enable;
    logic voltage_detect_irq_enable;
    logic crc_generator_irq_enable;
    logic uart2_error_irq_enable;
    logic uart1_error_irq_enable;
  } iepb_enables_t;

  typedef struct packed {
    iepb_level_t timer_one_priority;
    iepb_level_t compare_out_one_priority;
    iepb_level_t capture_in_one_priority;
    iepb_level_t ext_input0_priority;
    iepb_level_t timer_two_priority;
    iepb_level_t uart1_receive_priority;
    iepb_level_t spi_event_priority;
    iepb_level_t spi_fault_priority;
    iepb_level_t timer_three_priority;
    iepb_level_t nonvolatile_mem_priority;
    iepb_level_t converter_done_priority;
    iepb_level_t uart1_transmit_priority;
    iepb_level_t change_notify_priority;
    iepb_level_t comparator_priority;
    iepb_level_t i2c_master_event_priority;
    iepb_level_t i2c_slave_event_priority;
  } iepb_priorities_t;

  // requests handed to arbitration: sources with both an enable and a priority here
  typedef struct packed {
    logic valid;
    iepb_level_t level;
  } iepb_fwd_t;

endpackage : iepb_pkg

`default_nettype wire

// [iepb_bank.sv]
// interrupt enable and priority register bank with request gating
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "iepb_map.svh"

// Notes on behaviour
// - an enable bit at 1 lets its source request through and at 0 blocks it.
// - every implemented enable bit is read/write and is cleared at power-on.
// - unimplemented bits of all eight words read zero and ignore writes.
// - each source has a three-bit priority where 111 means level 7, the highest.
// - priority 001 means level 1, the lowest active, with codes between mapping straight.
// - priority 000 keeps the source from ever interrupting whatever its enable.
// - every implemented priority field comes up as 100 after power-on.
// - the first enable word holds the uart2, external 2/1, change, comparator and i2c enables.
// - the second enable word implements only bit 14, the clock calendar enable.
// - the third enable word holds charge measure, voltage detect, crc and uart errors.
// - the first priority word holds timer 1, compare 1, capture 1 and external 0 fields.
// - the second priority word holds only the timer 2 field in bits 14-12.
// - the third priority word holds uart1 receive, spi event, spi fault and timer 3.
// - the fourth priority word holds nonvolatile memory, converter and uart1 transmit.
// - the fifth priority word holds change notify, comparator and the two i2c fields.
module iepb_bank #(
  parameter int NUM_WORDS = 8,
  parameter int NUM_FWD = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] src_pending,
  output iepb_pkg::iepb_enables_t irq_enables,
  output iepb_pkg::iepb_priorities_t irq_priorities,
  output iepb_pkg::iepb_fwd_t [3:0] irq_fwd
);

  // ***********************************************
  // elaboration checks
  // ***********************************************
  if (NUM_WORDS != 8) begin : g_bad_words
    $error("iepb_bank serves exactly eight register words");
  end
  if (NUM_FWD != 4) begin : g_bad_fwd
    $error("iepb_bank gates exactly four shared sources");
  end

  // ***********************************************
  // reset release
  // ***********************************************
  logic rst_meta_r;
  logic rst_n;

  // release is synchronised so no flop leaves reset on a different edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ***********************************************
  // register words
  // ***********************************************
  localparam logic [3:0] OFS [0:7] = '{`IEPB_OFS_EN1, `IEPB_OFS_EN3, `IEPB_OFS_EN4,
    `IEPB_OFS_PRI0, `IEPB_OFS_PRI1, `IEPB_OFS_PRI2, `IEPB_OFS_PRI3, `IEPB_OFS_PRI4};
  localparam logic [15:0] MASK [0:7] = '{`IEPB_MASK_EN1, `IEPB_MASK_EN3, `IEPB_MASK_EN4,
    `IEPB_MASK_PRI0, `IEPB_MASK_PRI1, `IEPB_MASK_PRI2, `IEPB_MASK_PRI3, `IEPB_MASK_PRI4};
  localparam logic [15:0] RSTV [0:7] = '{`IEPB_RST_EN, `IEPB_RST_EN, `IEPB_RST_EN,
    `IEPB_RST_PRI0, `IEPB_RST_PRI1, `IEPB_RST_PRI2, `IEPB_RST_PRI3, `IEPB_RST_PRI4};

  iepb_pkg::iepb_bus_req_t bus;
  logic [15:0] word_r [0:7];

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        word_r[i] <= RSTV[i];
      end else if (bus.wr && bus.addr == OFS[i]) begin
        word_r[i] <= bus.wdata & MASK[i];
      end
    end
  end

  // ***********************************************
  // read port
  // ***********************************************
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;

  always_comb begin
    rdata_nxt = 16'h0000;
    if (!bus.rd) begin
      rdata_nxt = 16'h0000;
    end else if (bus.addr == `IEPB_OFS_EN1) begin
      rdata_nxt = word_r[0];
    end else if (bus.addr == `IEPB_OFS_EN3) begin
      rdata_nxt = word_r[1];
    end else if (bus.addr == `IEPB_OFS_EN4) begin
      rdata_nxt = word_r[2];
    end else if (bus.addr == `IEPB_OFS_PRI0) begin
      rdata_nxt = word_r[3];
    end else if (bus.addr == `IEPB_OFS_PRI1) begin
      rdata_nxt = word_r[4];
    end else if (bus.addr == `IEPB_OFS_PRI2) begin
      rdata_nxt = word_r[5];
    end else if (bus.addr == `IEPB_OFS_PRI3) begin
      rdata_nxt = word_r[6];
    end else if (bus.addr == `IEPB_OFS_PRI4) begin
      rdata_nxt = word_r[7];
    end
  end

  // unmapped reads answer zero; data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ***********************************************
  // field outputs, straight from the word flops
  // ***********************************************
  assign irq_enables.uart2_transmit_irq_enable = word_r[0][`IEPB_B_U2TX];
  assign irq_enables.uart2_receive_irq_enable = word_r[0][`IEPB_B_U2RX];
  assign irq_enables.ext_input2_irq_enable = word_r[0][`IEPB_B_EXT2];
  assign irq_enables.ext_input1_irq_enable = word_r[0][`IEPB_B_EXT1];
  assign irq_enables.change_notify_irq_enable = word_r[0][`IEPB_B_CN];
  assign irq_enables.comparator_irq_enable = word_r[0][`IEPB_B_CMP];
  assign irq_enables.i2c_master_event_irq_enable = word_r[0][`IEPB_B_I2CM];
  assign irq_enables.i2c_slave_event_irq_enable = word_r[0][`IEPB_B_I2CS];
  assign irq_enables.clock_calendar_irq_enable = word_r[1][`IEPB_B_RTC];
  assign irq_enables.charge_measure_irq_enable = word_r[2][`IEPB_B_CHG];
  assign irq_enables.voltage_detect_irq_enable = word_r[2][`IEPB_B_HLV];
  assign irq_enables.crc_generator_irq_enable = word_r[2][`IEPB_B_CRC];
  assign irq_enables.uart2_error_irq_enable = word_r[2][`IEPB_B_U2ER];
  assign irq_enables.uart1_error_irq_enable = word_r[2][`IEPB_B_U1ER];

  assign irq_priorities.timer_one_priority = word_r[3][`IEPB_F_HI];
  assign irq_priorities.compare_out_one_priority = word_r[3][`IEPB_F_MH];
  assign irq_priorities.capture_in_one_priority = word_r[3][`IEPB_F_ML];
  assign irq_priorities.ext_input0_priority = word_r[3][`IEPB_F_LO];
  assign irq_priorities.timer_two_priority = word_r[4][`IEPB_F_HI];
  assign irq_priorities.uart1_receive_priority = word_r[5][`IEPB_F_HI];
  assign irq_priorities.spi_event_priority = word_r[5][`IEPB_F_MH];
  assign irq_priorities.spi_fault_priority = word_r[5][`IEPB_F_ML];
  assign irq_priorities.timer_three_priority = word_r[5][`IEPB_F_LO];
  assign irq_priorities.nonvolatile_mem_priority = word_r[6][`IEPB_F_HI];
  assign irq_priorities.converter_done_priority = word_r[6][`IEPB_F_ML];
  assign irq_priorities.uart1_transmit_priority = word_r[6][`IEPB_F_LO];
  assign irq_priorities.change_notify_priority = word_r[7][`IEPB_F_HI];
  assign irq_priorities.comparator_priority = word_r[7][`IEPB_F_MH];
  assign irq_priorities.i2c_master_event_priority = word_r[7][`IEPB_F_ML];
  assign irq_priorities.i2c_slave_event_priority = word_r[7][`IEPB_F_LO];

  // ***********************************************
  // request gating
  // ***********************************************
  // index 3 change notify, 2 comparator, 1 i2c master, 0 i2c slave
  logic [3:0] gate_en;
  iepb_pkg::iepb_level_t gate_pri [0:3];
  iepb_pkg::iepb_fwd_t [3:0] fwd_r;

  assign gate_en = word_r[0][`IEPB_B_CN:`IEPB_B_I2CS];
  assign gate_pri[3] = word_r[7][`IEPB_F_HI];
  assign gate_pri[2] = word_r[7][`IEPB_F_MH];
  assign gate_pri[1] = word_r[7][`IEPB_F_ML];
  assign gate_pri[0] = word_r[7][`IEPB_F_LO];

  // level is the field itself: 111 -> 7 down to 001 -> 1; 000 never forwards
  for (genvar k = 0; k < NUM_FWD; k++) begin : g_fwd
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fwd_r[k] <= '0;
      end else if (src_pending[k] && gate_en[k] && gate_pri[k] != `IEPB_PRI_OFF) begin
        fwd_r[k] <= '{valid: 1'b1, level: gate_pri[k]};
      end else begin
        fwd_r[k] <= '0;
      end
    end
  end

  assign irq_fwd = fwd_r;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_en1;
    bus.wr && bus.addr == `IEPB_OFS_EN1;
  endsequence

  sequence s_rd_any;
    bus.rd;
  endsequence

  property p_enable_blocks;
    !gate_en[2] |=> !fwd_r[2].valid;
  endproperty
  a_enable_blocks: assert property (p_enable_blocks) else $error("blocked fwd");

  property p_en_write;
    s_wr_en1 |=> word_r[0] == ($past(bus.wdata) & `IEPB_MASK_EN1);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable word not written");

  property p_unimpl_zero;
    s_rd_any ##1 1'b1 |-> (reg_rdata & ~MASK[$past(bus.addr[2:0])]) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("stray bit read");

  property p_top_level;
    src_pending[3] && gate_en[3] && gate_pri[3] == `IEPB_PRI_TOP
      |=> fwd_r[3].valid && fwd_r[3].level == 3'h7;
  endproperty
  a_top_level: assert property (p_top_level) else $error("level 7 not forwarded");

  property p_bottom_level;
    src_pending[0] && gate_en[0] && gate_pri[0] == `IEPB_PRI_BOTTOM
      |=> fwd_r[0].valid && fwd_r[0].level == 3'h1;
  endproperty
  a_bottom_level: assert property (p_bottom_level) else $error("level 1 not forwarded");

  property p_off_level;
    gate_pri[1] == `IEPB_PRI_OFF |=> !fwd_r[1].valid;
  endproperty
  a_off_level: assert property (p_off_level) else $error("priority 0 forwarded");

  property p_pri_reset;
    $rose(rst_n) |-> irq_priorities.timer_two_priority == `IEPB_PRI_FIELD_RST
      && irq_enables == '0;
  endproperty
  a_pri_reset: assert property (p_pri_reset) else $error("bad power-on value");

  property p_cn_map;
    s_wr_en1 ##1 1'b1 |-> irq_enables.change_notify_irq_enable == $past(bus.wdata[3]);
  endproperty
  a_cn_map: assert property (p_cn_map) else $error("enable bit misplaced");

  property p_fwd_gate;
    fwd_r[2].valid |-> $past(src_pending[2] && gate_en[2]) && fwd_r[2].level != 3'h0;
  endproperty
  a_fwd_gate: assert property (p_fwd_gate) else $error("forward without cause");

  sequence s_wr_en3;
    bus.wr && bus.addr == `IEPB_OFS_EN3;
  endsequence

  sequence s_wr_en4;
    bus.wr && bus.addr == `IEPB_OFS_EN4;
  endsequence

  sequence s_wr_pri0;
    bus.wr && bus.addr == `IEPB_OFS_PRI0;
  endsequence

  sequence s_wr_pri1;
    bus.wr && bus.addr == `IEPB_OFS_PRI1;
  endsequence

  sequence s_wr_pri2;
    bus.wr && bus.addr == `IEPB_OFS_PRI2;
  endsequence

  sequence s_wr_pri3;
    bus.wr && bus.addr == `IEPB_OFS_PRI3;
  endsequence

  sequence s_wr_pri4;
    bus.wr && bus.addr == `IEPB_OFS_PRI4;
  endsequence

  property p_en3_write;
    s_wr_en3 |=> word_r[1] == ($past(bus.wdata) & `IEPB_MASK_EN3);
  endproperty
  a_en3_write: assert property (p_en3_write) else $error("calendar word lost");

  property p_en4_write;
    s_wr_en4 |=> word_r[2] == ($past(bus.wdata) & `IEPB_MASK_EN4);
  endproperty
  a_en4_write: assert property (p_en4_write) else $error("enable word 4 lost");

  property p_pri0_write;
    s_wr_pri0 |=> word_r[3] == ($past(bus.wdata) & `IEPB_MASK_PRI0);
  endproperty
  a_pri0_write: assert property (p_pri0_write) else $error("pri word 0 lost");

  property p_pri1_write;
    s_wr_pri1 |=> word_r[4] == ($past(bus.wdata) & `IEPB_MASK_PRI1);
  endproperty
  a_pri1_write: assert property (p_pri1_write) else $error("pri word 1 lost");

  property p_pri2_write;
    s_wr_pri2 |=> word_r[5] == ($past(bus.wdata) & `IEPB_MASK_PRI2);
  endproperty
  a_pri2_write: assert property (p_pri2_write) else $error("pri word 2 lost");

  property p_pri3_write;
    s_wr_pri3 |=> word_r[6] == ($past(bus.wdata) & `IEPB_MASK_PRI3);
  endproperty
  a_pri3_write: assert property (p_pri3_write) else $error("pri word 3 lost");

  property p_pri4_write;
    s_wr_pri4 |=> word_r[7] == ($past(bus.wdata) & `IEPB_MASK_PRI4);
  endproperty
  a_pri4_write: assert property (p_pri4_write) else $error("pri word 4 lost");

  // without a write the first enable word must not drift
  property p_en_hold;
    !(bus.wr && bus.addr == `IEPB_OFS_EN1) |=> $stable(word_r[0]);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable word drifted");

  property p_rd_unmapped;
    bus.rd && bus.addr > `IEPB_OFS_PRI4 |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read set");

  property p_rd_idle;
    !bus.rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data lingers");

  property p_fwd_level;
    fwd_r[3].valid |-> fwd_r[3].level == $past(gate_pri[3]);
  endproperty
  a_fwd_level: assert property (p_fwd_level) else $error("level not field");

  property p_off_quiet;
    !fwd_r[0].valid |-> fwd_r[0].level == `IEPB_PRI_OFF;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("idle level nonzero");

endmodule : iepb_bank

`default_nettype wire

// [iepb_src_model.sv]
// peripheral side model that raises the pending flags toward the bank
`timescale 1ns/1ns
`default_nettype none
module iepb_src_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] pend_req,
  input wire logic slow,
  output logic [3:0] src_pending
);
  logic [3:0] stage_r;
  // a slow source shows its flags a cycle late, like a peripheral behind a sync stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_r <= 4'h0;
      src_pending <= 4'h0;
    end else begin
      stage_r <= pend_req;
      src_pending <= slow ? stage_r : pend_req;
    end
  end
endmodule : iepb_src_model
`default_nettype wire

// [iepb_tb.sv]
// self-checking testbench of the interrupt enable and priority bank
`timescale 1ns/1ns
`default_nettype none
`include "iepb_map.svh"
module testbench;
  logic clk, rst_b, reg_wr, reg_rd, slow;
  logic [3:0] reg_addr, pend_req, src_pending;
  logic [15:0] reg_wdata, reg_rdata, seed;
  iepb_pkg::iepb_enables_t irq_enables;
  iepb_pkg::iepb_priorities_t irq_priorities;
  iepb_pkg::iepb_fwd_t [3:0] irq_fwd;
  int n_fail, num_checks;
  int m[8];
  int mask[8] = '{`IEPB_MASK_EN1, `IEPB_MASK_EN3, `IEPB_MASK_EN4, `IEPB_MASK_PRI0,
    `IEPB_MASK_PRI1, `IEPB_MASK_PRI2, `IEPB_MASK_PRI3, `IEPB_MASK_PRI4};
  int rstv[8] = '{`IEPB_RST_EN, `IEPB_RST_EN, `IEPB_RST_EN, `IEPB_RST_PRI0,
    `IEPB_RST_PRI1, `IEPB_RST_PRI2, `IEPB_RST_PRI3, `IEPB_RST_PRI4};

  iepb_bank DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_pending(src_pending),
    .irq_enables(irq_enables), .irq_priorities(irq_priorities), .irq_fwd(irq_fwd));
  iepb_src_model SRC (.clk(clk), .rst_b(rst_b), .pend_req(pend_req), .slow(slow),
    .src_pending(src_pending));

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 8) m[a] = d & mask[a];
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("read data", (a < 8) ? m[a] : 0, reg_rdata);
    @(posedge clk);
    #1;
    chk("read data idle", 0, reg_rdata);
  endtask : rd

  function automatic logic [13:0] exp_en();
    logic [15:0] a, b, c;
    a = m[0];
    b = m[1];
    c = m[2];
    return {a[15], a[14], a[13], a[4], a[3], a[2], a[1], a[0], b[14], c[13], c[8], c[3],
      c[2], c[1]};
  endfunction : exp_en

  function automatic logic [47:0] exp_pri();
    logic [15:0] p0, p1, p2, p3, p4;
    p0 = m[3];
    p1 = m[4];
    p2 = m[5];
    p3 = m[6];
    p4 = m[7];
    return {p0[14:12], p0[10:8], p0[6:4], p0[2:0], p1[14:12], p2[14:12], p2[10:8], p2[6:4],
      p2[2:0], p3[14:12], p3[6:4], p3[2:0], p4[14:12], p4[10:8], p4[6:4], p4[2:0]};
  endfunction : exp_pri

  task automatic check_regs();
    for (int a = 0; a < 16; a++) rd(a[3:0]);
    chk("enables", exp_en(), irq_enables);
    chk("priorities", exp_pri(), irq_priorities);
  endtask : check_regs

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ***********************************************
  // clock, watchdog and tests
  // ***********************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs about 800 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial begin
    logic [2:0] lvl;
    logic [3:0] pv;
    int pri;
    logic ev;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pend_req = 4'h0;
    slow = 1'b0;
    seed = 16'h0051;
    n_fail = 0;
    num_checks = 0;
    for (int i = 0; i < 8; i++) m[i] = rstv[i];
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check_regs();
    $display("test power-on values done");
    // ones, zeros, then random words, unmapped places included
    for (int r = 0; r < 6; r++) begin
      for (int a = 0; a < 16; a++) begin
        seed = lfsr(seed);
        wr(a[3:0], (r == 0) ? 16'hFFFF : ((r == 1) ? 16'h0000 : seed));
      end
      check_regs();
    end
    $display("test register access done");
    // every level with enables on, off and random; sources prompt and slow
    for (int i = 0; i < 24; i++) begin
      lvl = i[2:0];
      seed = lfsr(seed);
      wr(4'h0, (i < 8) ? 16'hFFFF : ((i < 16) ? 16'h0000 : seed));
      wr(4'h7, {4{1'b0, lvl}});
      pv = (i < 8) ? 4'hF : seed[3:0];
      @(posedge clk);
      pend_req <= pv;
      slow <= seed[4];
      repeat (4) @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++) begin
        pri = (m[7] >> (4 * k)) & 7;
        ev = pv[k] & m[0][k] & (pri != 0);
        chk("forward valid", ev, irq_fwd[k].valid);
        chk("forward level", ev ? pri : 0, irq_fwd[k].level);
      end
    end
    $display("test request forwarding done");
    @(posedge clk);
    rst_b <= 1'b0;
    pend_req <= 4'h0;
    #1;
    chk("forward in reset", 0, irq_fwd);
    chk("read data in reset", 0, reg_rdata);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) m[i] = rstv[i];
    repeat (3) @(posedge clk);
    check_regs();
    $display("test second reset done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
